// file: tb/paoc_apb_master.sv
// APB master model issuing single transfers from the bench.
// Assumes the slave samples on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "paoc_defs.vh"

module paoc_apb_master (
	input wire logic i_sys_clk, // Clock
	input wire logic i_pready, // Ready
	input wire logic [`PAOC_DATA_W-1:0] i_prdata, // Read data
	input wire logic i_pslverr, // Error response
	output logic o_psel, // Select
	output logic o_penable, // Enable
	output logic o_pwrite, // Write
	output logic [`PAOC_ADDR_W-1:0] o_paddr, // Address
	output logic [`PAOC_DATA_W-1:0] o_pwdata // Write data
);
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0000_0000;
	end

	// Only this master writes the control register
	task xfer(input logic wr, input logic [`PAOC_ADDR_W-1:0] addr,
		input logic [`PAOC_DATA_W-1:0] wdata,
		output logic [`PAOC_DATA_W-1:0] rdata,
		output logic err);
		@(negedge i_sys_clk);
		o_psel = 1'b1;
		o_pwrite = wr;
		o_paddr = addr;
		o_pwdata = wdata;
		@(negedge i_sys_clk);
		o_penable = 1'b1;
		@(posedge i_sys_clk);
		while (i_pready !== 1'b1)
			@(posedge i_sys_clk);
		rdata = i_prdata;
		err = i_pslverr;
		@(negedge i_sys_clk);
		// Stale lines flipped so they never pass for live ones
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_paddr = ~o_paddr;
		o_pwdata = ~o_pwdata;
	endtask
endmodule
`default_nettype wire

// file: tb/paoc_top_properties.sv
// Port assertions for the operand control block.
// Assumes binding into paoc_top, one clock and synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`include "paoc_defs.vh"

module paoc_top_properties (
	input wire logic i_sys_clk, // Clock
	input wire logic i_srst, // Reset
	input wire logic i_engine_busy, // Busy
	input wire logic [`PAOC_THR_W-1:0] i_thresh_evt, // Thresholds
	input wire logic i_seq_general_evt, // Event
	input wire logic i_seq_conv_evt, // Event
	input wire logic i_seq_cal_evt, // Event
	input wire logic i_seq_cmp_evt, // Event
	input wire logic o_postproc_enable, // Enable bit
	input wire logic o_postproc_idle_flag, // Idle bit
	input wire logic [`PAOC_THR_W-1:0] o_fabric_thresh_flags, // Flags
	input wire logic o_postproc_irq, // Irq
	input wire logic o_seq_irq, // Irq
	input wire logic o_proc_irq // Irq
);
	wire seq_any = i_seq_general_evt | i_seq_conv_evt | i_seq_cal_evt |
		i_seq_cmp_evt;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	a_idle_busy: assert property (i_engine_busy |=> !o_postproc_idle_flag)
		else $error("idle flag high while busy");
	a_idle_free: assert property (!i_engine_busy |=> o_postproc_idle_flag)
		else $error("idle flag low while free");
	a_thresh_pass: assert property (o_postproc_enable |=>
		o_fabric_thresh_flags == $past(i_thresh_evt))
		else $error("threshold flags do not follow events");
	a_thresh_block: assert property (!o_postproc_enable |=>
		o_fabric_thresh_flags == 32'h0000_0000 && !o_postproc_irq)
		else $error("threshold seen while disabled");
	a_thresh_irq: assert property (
		o_postproc_enable && |i_thresh_evt |=> o_postproc_irq)
		else $error("threshold interrupt missing");
	a_seq_irq: assert property (seq_any |=> o_seq_irq)
		else $error("sequencer interrupt missing");
	a_seq_quiet: assert property (!seq_any |=> !o_seq_irq)
		else $error("sequencer interrupt without event");
	a_proc_merge: assert property (
		o_proc_irq == (o_postproc_irq || o_seq_irq))
		else $error("processor line not the merge of both");
endmodule

bind paoc_top paoc_top_properties u_props (
	.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_engine_busy(i_engine_busy),
	.i_thresh_evt(i_thresh_evt), .i_seq_general_evt(i_seq_general_evt),
	.i_seq_conv_evt(i_seq_conv_evt), .i_seq_cal_evt(i_seq_cal_evt),
	.i_seq_cmp_evt(i_seq_cmp_evt), .o_postproc_enable(o_postproc_enable),
	.o_postproc_idle_flag(o_postproc_idle_flag), .o_seq_irq(o_seq_irq),
	.o_fabric_thresh_flags(o_fabric_thresh_flags), .o_proc_irq(o_proc_irq),
	.o_postproc_irq(o_postproc_irq)
);
`default_nettype wire

// file: tb/postproc_alu_operand_control_tb.sv
// Self-checking bench for the operand control block.
// Assumes the APB master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "paoc_defs.vh"

module postproc_alu_operand_control_tb;
	logic i_sys_clk;
	logic i_srst;
	logic i_engine_busy;
	logic [31:0] i_thresh_evt;
	logic [3:0] seq_evt;
	logic [31:0] rdata;
	logic err;
	wire pslverr;
	wire psel, penable, pwrite, pready, enable, idle, pp_irq, seq_irq, proc_irq;
	wire [7:0] paddr;
	wire [31:0] pwdata, prdata, b_value, flags;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	paoc_apb_master bus (.i_sys_clk(i_sys_clk), .i_pready(pready),
		.i_prdata(prdata), .i_pslverr(pslverr), .o_psel(psel),
		.o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr),
		.o_pwdata(pwdata));

	paoc_top DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
		.o_pslverr(pslverr), .i_engine_busy(i_engine_busy),
		.i_thresh_evt(i_thresh_evt), .i_seq_general_evt(seq_evt[0]),
		.i_seq_conv_evt(seq_evt[1]), .i_seq_cal_evt(seq_evt[2]),
		.i_seq_cmp_evt(seq_evt[3]), .o_postproc_enable(enable),
		.o_postproc_idle_flag(idle), .o_b_value(b_value),
		.o_fabric_thresh_flags(flags), .o_postproc_irq(pp_irq),
		.o_seq_irq(seq_irq), .o_proc_irq(proc_irq));

	task print_verdict;
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 1000) begin
			fails++;
			print_verdict;
		end
	end

	task check(input string name, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus.xfer(1'b1, a, d, rdata, err);
	endtask

	task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		bus.xfer(1'b0, a, 32'h0000_0000, rdata, err);
		check(name, exp, rdata);
	endtask

	// One-cycle event pulse; outputs read once it is registered
	task pulse(input logic [31:0] thr, input logic [3:0] seq);
		@(negedge i_sys_clk);
		i_thresh_evt = thr;
		seq_evt = seq;
		@(negedge i_sys_clk);
		i_thresh_evt = 32'h0000_0000;
		seq_evt = 4'h0;
	endtask

	task t_operands;
		logic [31:0] ctl [0:4];
		logic [31:0] sum [0:4];
		ctl = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h84};
		sum = '{32'h1234_5688, 32'hedcb_a997, 32'ha000_0013, 32'ha000_0013,
			32'hedcb_a998};
		wr(`PAOC_OFF_A, 32'h1234_5678);
		wr(`PAOC_OFF_B, 32'h0000_0010);
		wr(`PAOC_OFF_C, 32'ha000_0003);
		for (int i = 0; i < 5; i++) begin
			wr(`PAOC_OFF_CTRL, ctl[i]);
			rd("sum", `PAOC_OFF_SUM, sum[i]);
		end
	endtask

	task t_pulses;
		wr(`PAOC_OFF_CTRL, 32'h0000_0018);
		rd("b", `PAOC_OFF_B, 32'ha000_0013);
		check("b_port", 32'ha000_0013, b_value);
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_000a);
		wr(`PAOC_OFF_D, 32'h0000_fffe);
		wr(`PAOC_OFF_X, 32'h0000_0003);
		rd("d", `PAOC_OFF_D, 32'h0000_fffe);
		rd("b", `PAOC_OFF_B, 32'hffff_fffa);
		wr(`PAOC_OFF_C, 32'h0005_0000);
		wr(`PAOC_OFF_CTRL, 32'h0000_0020);
		rd("b", `PAOC_OFF_B, 32'h0000_000f);
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_0002);
	endtask

	task t_status;
		i_engine_busy = 1'b1;
		wr(`PAOC_OFF_CTRL, 32'h0000_0003);
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_0001);
		i_engine_busy = 1'b0;
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_0003);
	endtask

	// Lines are only watched here, never cleared by the receiver
	task t_events;
		pulse(32'h8000_0001, 4'h0);
		check("flags", 32'h8000_0001, flags);
		check("irqs", 32'h5, {29'h0, pp_irq, seq_irq, proc_irq});
		for (int k = 0; k < 4; k++) begin
			pulse(32'h0, 4'h1 << k);
			check("seq", 32'h3, {29'h0, pp_irq, seq_irq, proc_irq});
		end
		wr(`PAOC_OFF_CTRL, 32'h0000_0000);
		pulse(32'hffff_ffff, 4'h0);
		check("off", 32'h0, {flags[30:0], pp_irq});
	endtask

	// Unmapped offset flags an error; a write to SUM is ignored
	task t_bus_err;
		wr(8'h1c, 32'h0000_0001);
		check("err_wr", 32'h1, {31'h0, err});
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_0002);
		check("err_rd", 32'h0, {31'h0, err});
		wr(`PAOC_OFF_SUM, 32'hffff_ffff);
		rd("sum", `PAOC_OFF_SUM, 32'h1234_5687);
	endtask

	// Mid-run reset returns every control bit to its reset value
	task t_reset;
		wr(`PAOC_OFF_CTRL, 32'h0000_008d);
		@(negedge i_sys_clk);
		i_srst = 1'b1;
		repeat (2) @(negedge i_sys_clk);
		i_srst = 1'b0;
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_0002);
		rd("sum", `PAOC_OFF_SUM, 32'h0000_0000);
	endtask

	initial begin
		i_srst = 1'b1;
		i_engine_busy = 1'b0;
		i_thresh_evt = 32'h0000_0000;
		seq_evt = 4'h0;
		repeat (10) @(negedge i_sys_clk);
		i_srst = 1'b0;
		rd("ctrl", `PAOC_OFF_CTRL, 32'h0000_0002);
		t_operands;
		t_pulses;
		t_status;
		t_events;
		t_bus_err;
		t_reset;
		print_verdict;
	end
endmodule
`default_nettype wire

// file: verilog/paoc_alu.v
// Operand steering, signed multiplier and 32-bit adder.
// Assumes register values come from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "paoc_defs.vh"

module paoc_alu (
	input wire [`PAOC_DATA_W-1:0] i_a, // A register
	input wire [`PAOC_DATA_W-1:0] i_b, // B register, adder b operand
	input wire [`PAOC_DATA_W-1:0] i_c, // C register
	input wire [`PAOC_HALF_W-1:0] i_d, // D register
	input wire [`PAOC_HALF_W-1:0] i_x, // Multiplier x operand
	input wire i_upper_c_to_mult_select, // C upper half to d
	input wire i_c_to_adder_select, // C to adder a
	input wire i_invert_a_select, // One's complement of A
	input wire i_adder_carry_in, // Adder carry input
	output wire [`PAOC_DATA_W-1:0] o_sum, // Adder sum s
	output wire [`PAOC_DATA_W-1:0] o_product // Signed product p
);

	wire [`PAOC_HALF_W-1:0] d_operand;
	wire [`PAOC_DATA_W-1:0] a_from_a;
	wire [`PAOC_DATA_W-1:0] a_operand;

	assign d_operand = i_upper_c_to_mult_select ? // RL1
		i_c[`PAOC_CUP_HI:`PAOC_CUP_LO] : i_d;
	assign a_from_a = i_invert_a_select ? ~i_a : i_a; // RL7
	assign a_operand = i_c_to_adder_select ? i_c : a_from_a; // RL5 RL6
	assign o_sum = a_operand + i_b +
		{{(`PAOC_DATA_W-1){1'b0}}, i_adder_carry_in}; // RL13
	assign o_product = $signed(i_x) * $signed(d_operand);

endmodule
`default_nettype wire

// file: verilog/paoc_defs.vh
// Constants for the post-processing ALU operand control block.
// Assumes inclusion by bare name from the block's design files.
`ifndef PAOC_DEFS_VH
`define PAOC_DEFS_VH

`define PAOC_ADDR_W 8
`define PAOC_DATA_W 32
`define PAOC_HALF_W 16
`define PAOC_THR_W 32

`define PAOC_OFF_CTRL 8'h00
`define PAOC_OFF_A 8'h04
`define PAOC_OFF_B 8'h08
`define PAOC_OFF_C 8'h0c
`define PAOC_OFF_D 8'h10
`define PAOC_OFF_X 8'h14
`define PAOC_OFF_SUM 8'h18

`define PAOC_BIT_EN 0
`define PAOC_BIT_IDLE 1
`define PAOC_BIT_INVERT_A_SELECT 2
`define PAOC_BIT_C2A 3
`define PAOC_BIT_S2B 4
`define PAOC_BIT_C2D 5
`define PAOC_BIT_CARRY 7

`define PAOC_CUP_HI 31
`define PAOC_CUP_LO 16

`define PAOC_ZERO32 32'h0000_0000
`define PAOC_ZERO16 16'h0000
`define PAOC_IDLE_RST 1'b1

`endif

// file: verilog/paoc_irq.v
// Routes engine events to the processor and fabric interrupt lines.
// Assumes event inputs are single-clock pulses from same-clock logic.
`timescale 1ns/1ps
`default_nettype none
`include "paoc_defs.vh"

module paoc_irq (
	input wire i_sys_clk, // System clock
	input wire i_srst, // Synchronous reset, high
	input wire i_postproc_enable, // Engine enabled
	input wire [`PAOC_THR_W-1:0] i_thresh_evt, // Threshold events
	input wire i_seq_general_evt, // Sequencer general event
	input wire i_seq_conv_evt, // Conversion event
	input wire i_seq_cal_evt, // Calibration event
	input wire i_seq_cmp_evt, // Comparator event
	output reg [`PAOC_THR_W-1:0] o_fabric_thresh_flags, // To fabric
	output reg o_postproc_irq, // Threshold interrupt
	output reg o_seq_irq, // Sequencer interrupt
	output wire o_proc_irq // Combined line to processor
);

	wire [`PAOC_THR_W-1:0] thresh_gated;

	// Threshold flags only mean something while the engine runs
	assign thresh_gated = i_postproc_enable ? i_thresh_evt :
		{`PAOC_THR_W{1'b0}};

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_fabric_thresh_flags <= {`PAOC_THR_W{1'b0}};
			o_postproc_irq <= 1'b0;
			o_seq_irq <= 1'b0;
		end else begin
			o_fabric_thresh_flags <= thresh_gated; // RL11
			o_postproc_irq <= |thresh_gated; // RL11
			o_seq_irq <= i_seq_general_evt | i_seq_conv_evt |
				i_seq_cal_evt | i_seq_cmp_evt; // RL11
		end
	end

	// Masking is left to the receiver; the merge itself holds no state
	assign o_proc_irq = o_postproc_irq | o_seq_irq; // RL10

endmodule
`default_nettype wire

// file: verilog/paoc_top.v
// Post-processing ALU operand control register with APB slave access.
// Assumes an APB master on i_sys_clk and engine logic on the same clock.
// Behaviour
// RL1 - Writing one to bit 5 feeds C[31:16] to the multiplier d operand.
// RL2 - Bits 5 and 4 are pulses that clear themselves one clock later.
// RL3 - Writing one to bit 4 loads the adder sum into B.
// RL4 - With bit 4 low, B takes the signed product on each multiply update.
// RL5 - With bit 3 high, the full C register is the adder a operand.
// RL6 - With bit 3 low, adder a comes from A or its complement.
// RL7 - Bit 2 high selects the one's complement of A, low selects A.
// RL8 - Bit 1 reads one when the engine is idle, resets to one.
// RL9 - Bit 0 enables the engine, resets to zero, written only over APB.
// RL10 - Interrupts of both engines reach the processor and the fabric.
// RL11 - Threshold and sequencer event classes each raise interrupts.
// RL12 - The receiver services, masks or ignores these interrupts.
// RL13 - Bit 7 drives the carry input of the 32-bit adder.
// RL14 - Writes to the idle bit do nothing; pulse bits normally read zero.
`timescale 1ns/1ps
`default_nettype none
`include "paoc_defs.vh"

module paoc_top (
	input wire i_sys_clk, // Bus clock
	input wire i_srst, // Synchronous reset, high
	input wire i_psel, // APB select
	input wire i_penable, // APB enable
	input wire i_pwrite, // APB write
	input wire [`PAOC_ADDR_W-1:0] i_paddr, // APB byte address
	input wire [`PAOC_DATA_W-1:0] i_pwdata, // APB write data
	output wire o_pready, // APB ready
	output reg [`PAOC_DATA_W-1:0] o_prdata, // APB read data
	output wire o_pslverr, // APB error
	input wire i_engine_busy, // Engine processing
	input wire [`PAOC_THR_W-1:0] i_thresh_evt, // Threshold events
	input wire i_seq_general_evt, // Sequencer general event
	input wire i_seq_conv_evt, // Conversion event
	input wire i_seq_cal_evt, // Calibration event
	input wire i_seq_cmp_evt, // Comparator event
	output wire o_postproc_enable, // Engine enable
	output wire o_postproc_idle_flag, // Idle status
	output wire [`PAOC_DATA_W-1:0] o_b_value, // B register
	output wire [`PAOC_THR_W-1:0] o_fabric_thresh_flags, // To fabric
	output wire o_postproc_irq, // Threshold interrupt
	output wire o_seq_irq, // Sequencer interrupt
	output wire o_proc_irq // Processor interrupt
);

	reg postproc_enable_reg;
	reg postproc_idle_flag_reg;
	reg invert_a_select_reg;
	reg c_to_adder_select_reg;
	reg sum_to_b_select_reg;
	reg upper_c_to_mult_select_reg;
	reg adder_carry_in_reg;
	reg [`PAOC_DATA_W-1:0] a_reg;
	reg [`PAOC_DATA_W-1:0] b_reg;
	reg [`PAOC_DATA_W-1:0] b_next;
	reg [`PAOC_DATA_W-1:0] c_reg;
	reg [`PAOC_HALF_W-1:0] d_reg;
	reg [`PAOC_HALF_W-1:0] x_reg;
	reg [`PAOC_DATA_W-1:0] rd_next;

	wire access_phase;
	wire unmapped_access;
	wire wr_access;
	wire rd_setup;
	wire wr_ctrl;
	wire wr_a;
	wire wr_b;
	wire wr_c;
	wire wr_d;
	wire wr_x;
	wire mult_update;
	reg [`PAOC_DATA_W-1:0] ctrl_view;
	wire [`PAOC_DATA_W-1:0] alu_sum;
	wire [`PAOC_DATA_W-1:0] alu_product;

	function hit;
		input [`PAOC_ADDR_W-1:0] addr;
		input [`PAOC_ADDR_W-1:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	function mapped;
		input [`PAOC_ADDR_W-1:0] addr;
		begin
			mapped = hit(addr, `PAOC_OFF_CTRL) | hit(addr, `PAOC_OFF_A) |
				hit(addr, `PAOC_OFF_B) | hit(addr, `PAOC_OFF_C) |
				hit(addr, `PAOC_OFF_D) | hit(addr, `PAOC_OFF_X) |
				hit(addr, `PAOC_OFF_SUM);
		end
	endfunction

	// Zero wait states; the register file never stalls the master
	assign o_pready = 1'b1;
	assign access_phase = i_psel & i_penable;
	// Unmapped access flags an error but touches no state
	assign unmapped_access = access_phase & ~mapped(i_paddr);
	assign o_pslverr = unmapped_access;
	assign wr_access = access_phase & i_pwrite & mapped(i_paddr);
	assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
	// Only the APB path can write the enable bit
	assign wr_ctrl = wr_access & hit(i_paddr, `PAOC_OFF_CTRL); // RL9
	// One strobe per data register, live in the access cycle only
	assign wr_a = wr_access & hit(i_paddr, `PAOC_OFF_A);
	assign wr_b = wr_access & hit(i_paddr, `PAOC_OFF_B);
	assign wr_c = wr_access & hit(i_paddr, `PAOC_OFF_C);
	assign wr_d = wr_access & hit(i_paddr, `PAOC_OFF_D);
	assign wr_x = wr_access & hit(i_paddr, `PAOC_OFF_X);

	// Product is taken into B when x or d is written or C feeds d
	assign mult_update = wr_x | wr_d | upper_c_to_mult_select_reg;

	// Enable has its own process: only the bus write path reaches it
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			postproc_enable_reg <= 1'b0;
		end else if (wr_ctrl) begin
			postproc_enable_reg <= i_pwdata[`PAOC_BIT_EN]; // RL9
		end
	end

	// Steering bits hold until the next control write
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			invert_a_select_reg <= 1'b0;
			c_to_adder_select_reg <= 1'b0;
			adder_carry_in_reg <= 1'b0;
		end else if (wr_ctrl) begin
			invert_a_select_reg <= i_pwdata[`PAOC_BIT_INVERT_A_SELECT]; // RL7
			c_to_adder_select_reg <= i_pwdata[`PAOC_BIT_C2A]; // RL5
			adder_carry_in_reg <= i_pwdata[`PAOC_BIT_CARRY]; // RL13
		end
	end

	// Pulse bits: a write sets them, any other cycle clears them, so
	// each lasts one clock since two control writes never abut
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			upper_c_to_mult_select_reg <= 1'b0;
			sum_to_b_select_reg <= 1'b0;
		end else if (wr_ctrl) begin
			upper_c_to_mult_select_reg <= i_pwdata[`PAOC_BIT_C2D]; // RL1
			sum_to_b_select_reg <= i_pwdata[`PAOC_BIT_S2B]; // RL3
		end else begin
			upper_c_to_mult_select_reg <= 1'b0; // RL2
			sum_to_b_select_reg <= 1'b0; // RL2
		end
	end

	// Idle bit follows the engine only; bus writes never reach it
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			postproc_idle_flag_reg <= `PAOC_IDLE_RST; // RL8
		end else begin
			postproc_idle_flag_reg <= ~i_engine_busy; // RL8 RL14
		end
	end

	// Data registers, each loaded only by its own strobe
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			a_reg <= `PAOC_ZERO32;
		end else if (wr_a) begin
			a_reg <= i_pwdata;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			c_reg <= `PAOC_ZERO32;
		end else if (wr_c) begin
			c_reg <= i_pwdata;
		end
	end

	// D and X keep the low half; upper write bits are dropped
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			d_reg <= `PAOC_ZERO16;
		end else if (wr_d) begin
			d_reg <= i_pwdata[`PAOC_HALF_W-1:0];
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			x_reg <= `PAOC_ZERO16;
		end else if (wr_x) begin
			x_reg <= i_pwdata[`PAOC_HALF_W-1:0];
		end
	end

	// Multiply on an x or d write uses the new operand next cycle
	reg mult_pending_reg;
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			mult_pending_reg <= 1'b0;
		end else begin
			mult_pending_reg <= mult_update & ~upper_c_to_mult_select_reg;
		end
	end

	// The sum pulse wins over a product update in the same cycle
	always @* begin
		b_next = b_reg;
		if (sum_to_b_select_reg) begin
			b_next = alu_sum; // RL3
		end else if (mult_pending_reg | upper_c_to_mult_select_reg) begin
			b_next = alu_product; // RL4
		end else if (wr_b) begin
			b_next = i_pwdata;
		end
	end

	// B has three writers; b_next above ranks them
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			b_reg <= `PAOC_ZERO32;
		end else begin
			b_reg <= b_next;
		end
	end

	paoc_alu u_alu (
		.i_a(a_reg),
		.i_b(b_reg),
		.i_c(c_reg),
		.i_d(d_reg),
		.i_x(x_reg),
		.i_upper_c_to_mult_select(upper_c_to_mult_select_reg),
		.i_c_to_adder_select(c_to_adder_select_reg),
		.i_invert_a_select(invert_a_select_reg),
		.i_adder_carry_in(adder_carry_in_reg),
		.o_sum(alu_sum),
		.o_product(alu_product)
	);

	// Reserved bits stay zero; pulse bits read live
	always @* begin
		ctrl_view = `PAOC_ZERO32;
		ctrl_view[`PAOC_BIT_EN] = postproc_enable_reg;
		ctrl_view[`PAOC_BIT_IDLE] = postproc_idle_flag_reg;
		ctrl_view[`PAOC_BIT_INVERT_A_SELECT] = invert_a_select_reg;
		ctrl_view[`PAOC_BIT_C2A] = c_to_adder_select_reg;
		ctrl_view[`PAOC_BIT_S2B] = sum_to_b_select_reg; // RL14
		ctrl_view[`PAOC_BIT_C2D] = upper_c_to_mult_select_reg; // RL14
		ctrl_view[`PAOC_BIT_CARRY] = adder_carry_in_reg;
	end

	// Read data is captured in the setup phase, stable in access
	always @* begin
		rd_next = `PAOC_ZERO32;
		if (hit(i_paddr, `PAOC_OFF_CTRL)) begin
			rd_next = ctrl_view;
		end else if (hit(i_paddr, `PAOC_OFF_A)) begin
			rd_next = a_reg;
		end else if (hit(i_paddr, `PAOC_OFF_B)) begin
			rd_next = b_reg;
		end else if (hit(i_paddr, `PAOC_OFF_C)) begin
			rd_next = c_reg;
		end else if (hit(i_paddr, `PAOC_OFF_D)) begin
			rd_next = {`PAOC_ZERO16, d_reg};
		end else if (hit(i_paddr, `PAOC_OFF_X)) begin
			rd_next = {`PAOC_ZERO16, x_reg};
		end else if (hit(i_paddr, `PAOC_OFF_SUM)) begin
			rd_next = alu_sum;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_prdata <= `PAOC_ZERO32;
		end else if (rd_setup) begin
			o_prdata <= rd_next;
		end
	end

	assign o_postproc_enable = postproc_enable_reg;
	assign o_postproc_idle_flag = postproc_idle_flag_reg;
	assign o_b_value = b_reg;

	paoc_irq u_irq (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_postproc_enable(postproc_enable_reg),
		.i_thresh_evt(i_thresh_evt),
		.i_seq_general_evt(i_seq_general_evt),
		.i_seq_conv_evt(i_seq_conv_evt),
		.i_seq_cal_evt(i_seq_cal_evt),
		.i_seq_cmp_evt(i_seq_cmp_evt),
		.o_fabric_thresh_flags(o_fabric_thresh_flags),
		.o_postproc_irq(o_postproc_irq),
		.o_seq_irq(o_seq_irq),
		.o_proc_irq(o_proc_irq)
	); // RL10 RL11

endmodule
`default_nettype wire
